// ### hw/dual_port_bus_match_counter.v
// port-side logic of a 36-bit dual-port memory: burst counters, read-back,
// left byte lanes and right-port bus matching, plus an apb config slave.
// assumes the host buses and the memory array run on mclk; the array reads
// combinationally at its address and writes per lane at the clock edge.
`timescale 1ns/1ps
`include "bus_match_consts.vh"

module dual_port_bus_match_counter (
  input wire mclk,
  input wire srst,
  input wire [`APB_AW-1:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [`ADDR_W-1:0] addrLeft,
  input wire addressStrobeLoadLeftN,
  input wire countAdvanceEnableLeftN,
  input wire counterClearLeftN,
  input wire chipEnableLeftN,
  input wire readNotWriteLeft,
  input wire outputEnableLeftN,
  input wire byteLaneEnable0N,
  input wire byteLaneEnable1N,
  input wire byteLaneEnable2N,
  input wire byteLaneEnable3N,
  input wire [`DATA_W-1:0] dataInLeft,
  output wire [`DATA_W-1:0] dataOutLeft,
  output wire [`LANES-1:0] dataOeLeft,
  output wire [`ADDR_W-1:0] memAddrLeft,
  output wire memWriteLeft,
  output wire [`LANES-1:0] memLaneEnLeft,
  output wire [`DATA_W-1:0] memWdataLeft,
  input wire [`DATA_W-1:0] memRdataLeft,
  input wire [`ADDR_W-1:0] addrRight,
  input wire addressStrobeLoadRightN,
  input wire countAdvanceEnableRightN,
  input wire counterClearRightN,
  input wire chipEnableRightN,
  input wire readNotWriteRight,
  input wire outputEnableRightN,
  input wire [`DATA_W-1:0] dataInRight,
  output wire [`DATA_W-1:0] dataOutRight,
  output wire [`LANES-1:0] dataOeRight,
  output wire [`ADDR_W-1:0] memAddrRight,
  output wire [`SUB_W-1:0] memSubRight,
  output wire memWriteRight,
  output wire [`LANES-1:0] memLaneEnRight,
  output wire [`DATA_W-1:0] memWdataRight,
  input wire [`DATA_W-1:0] memRdataRight
);

  // ----------------------------------------------------------------------------
  // counter operations
  // ----------------------------------------------------------------------------
  localparam [2:0] OP_CLEAR = 3'h0;
  localparam [2:0] OP_LOAD = 3'h1;
  localparam [2:0] OP_READBACK = 3'h2;
  localparam [2:0] OP_HOLD = 3'h3;
  localparam [2:0] OP_INC = 3'h4;
  reg [`CFG_W-1:0] cfg_q;
  reg [31:0] prdata_q;
  reg pslverr_q;
  reg [`ADDR_W-1:0] cntLeft_q;
  reg [`ADDR_W-1:0] cntLeft_d;
  reg [`ADDR_W-1:0] cntRight_q;
  reg [`ADDR_W-1:0] cntRight_d;
  reg [`SUB_W-1:0] subRight_q;
  reg [`SUB_W-1:0] subRight_d;
  reg [2:0] opLeft;
  reg [2:0] opRight;
  reg wrLeft_q;
  reg rdLeft_q;
  reg rbLeft_q;
  reg [`LANES-1:0] laneLeft_q;
  reg [`DATA_W-1:0] wdataLeft_q;
  reg [`DATA_W-1:0] doutLeft_q;
  reg [`LANES-1:0] oeLeft_q;
  reg wrRight_q;
  reg rdRight_q;
  reg rbRight_q;
  reg rbPhaseRight_q;
  reg rbExtRight_q;
  reg [`LANES-1:0] laneRight_q;
  reg [`DATA_W-1:0] wdataRight_q;
  reg [`DATA_W-1:0] doutRight_q;
  reg [`LANES-1:0] oeRight_q;
  reg [`SUB_W-1:0] subFirst;
  reg [`SUB_W-1:0] subLast;
  reg [`SUB_W-1:0] subStep;
  reg [`LANES-1:0] laneRightNext;
  wire laneMatchEnable = cfg_q[`CFG_BM_BIT];
  wire widthSelect = cfg_q[`CFG_SIZE_BIT];
  wire endianOrderSelect = cfg_q[`CFG_BE_BIT];
  // unused combination (match off, width 1) falls back to the full word
  wire modeX18 = laneMatchEnable & ~widthSelect;
  wire modeX9 = laneMatchEnable & widthSelect;
  wire modeMatched = laneMatchEnable;
  wire halfWordBit = subRight_q[1];
  wire byteBit = subRight_q[0];

  // ----------------------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------------------
  wire apbSetup = psel & ~penable;
  wire apbAccess = psel & penable;
  wire hitCfg = (paddr == `OFS_CFG);
  wire hitCntLeft = (paddr == `OFS_CNT_LEFT);
  wire hitCntRight = (paddr == `OFS_CNT_RIGHT);
  wire hitAny = hitCfg | hitCntLeft | hitCntRight;
  // zero wait: read data is staged in the setup cycle so it leaves a flop
  assign pready = apbAccess;
  assign pslverr = apbAccess & pslverr_q;
  assign prdata = prdata_q;
  always @(posedge mclk) begin
    if (srst) begin
      cfg_q <= `CFG_RESET;
      prdata_q <= `WORD_ZERO;
      pslverr_q <= 1'b0;
    end else begin
      if (apbSetup) begin
        pslverr_q <= ~hitAny;
        prdata_q <= `WORD_ZERO;
        if (!pwrite && hitCfg) begin
          prdata_q <= {{(32-`CFG_W){1'b0}}, cfg_q};
        end
        if (!pwrite && hitCntLeft) begin
          prdata_q <= {{(32-`ADDR_W){1'b0}}, cntLeft_q};
        end
        if (!pwrite && hitCntRight) begin
          prdata_q <= {{(32-`ADDR_W-`SUB_W){1'b0}}, subRight_q, cntRight_q};
        end
      end
      // configuration lands one edge before any port cycle can use it
      if (apbAccess && pwrite && hitCfg && pstrb[0]) begin
        cfg_q <= pwdata[`CFG_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // counter control decode
  // ----------------------------------------------------------------------------
  // chip enable takes no part here by design
  always @* begin
    if (!counterClearLeftN) begin
      opLeft = OP_CLEAR;
    end else if (!addressStrobeLoadLeftN && !countAdvanceEnableLeftN) begin
      opLeft = OP_LOAD;
    end else if (!addressStrobeLoadLeftN) begin
      opLeft = OP_READBACK;
    end else if (countAdvanceEnableLeftN) begin
      opLeft = OP_HOLD;
    end else begin
      opLeft = OP_INC;
    end
  end

  always @* begin
    if (!counterClearRightN) begin
      opRight = OP_CLEAR;
    end else if (!addressStrobeLoadRightN && !countAdvanceEnableRightN) begin
      opRight = OP_LOAD;
    end else if (!addressStrobeLoadRightN) begin
      opRight = OP_READBACK;
    end else if (countAdvanceEnableRightN) begin
      opRight = OP_HOLD;
    end else begin
      opRight = OP_INC;
    end
  end

  // ----------------------------------------------------------------------------
  // left burst counter, 36-bit only
  // ----------------------------------------------------------------------------
  always @* begin
    case (opLeft)
      OP_CLEAR: begin
        cntLeft_d = `CNT_RESET;
      end
      OP_LOAD: begin
        cntLeft_d = addrLeft;
      end
      OP_INC: begin
        cntLeft_d = cntLeft_q + `CNT_ONE;
      end
      default: begin
        cntLeft_d = cntLeft_q;
      end
    endcase
  end

  // ----------------------------------------------------------------------------
  // right burst counter with two-bit sub-counter
  // ----------------------------------------------------------------------------
  // sub-counter is {half-word bit, byte bit}; x18 steps only the upper bit
  always @* begin
    subStep = modeX9 ? `SUB_STEP_X9 : `SUB_STEP_X18;
    if (endianOrderSelect) begin
      subFirst = modeX9 ? `SUB_LAST_X9 : `SUB_LAST_X18;
      subLast = `SUB_FIRST_LE;
    end else begin
      subFirst = `SUB_FIRST_LE;
      subLast = modeX9 ? `SUB_LAST_X9 : `SUB_LAST_X18;
    end
    if (!modeMatched) begin
      subFirst = `SUB_FIRST_LE;
      subLast = `SUB_FIRST_LE;
    end
  end

  always @* begin
    cntRight_d = cntRight_q;
    subRight_d = subRight_q;
    case (opRight)
      OP_CLEAR: begin
        cntRight_d = `CNT_RESET;
        subRight_d = subFirst;
      end
      OP_LOAD: begin
        cntRight_d = addrRight;
        subRight_d = subFirst;
      end
      OP_INC: begin
        if (!modeMatched || subRight_q == subLast) begin
          cntRight_d = cntRight_q + `CNT_ONE;
          subRight_d = subFirst;
        end else if (endianOrderSelect) begin
          subRight_d = subRight_q - subStep;
        end else begin
          subRight_d = subRight_q + subStep;
        end
      end
      default: begin
        cntRight_d = cntRight_q;
      end
    endcase
  end
  // lanes touched by the piece that the updated sub-counter points at
  always @* begin
    if (modeX9) begin
      laneRightNext = `LANES_FIRST << subRight_d;
    end else if (modeX18) begin
      laneRightNext = subRight_d[1] ? `LANES_HIGH_HALF : `LANES_LOW_HALF;
    end else begin
      laneRightNext = `LANES_ALL;
    end
  end

  // ----------------------------------------------------------------------------
  // left port request stage and output stage
  // ----------------------------------------------------------------------------
  assign memAddrLeft = cntLeft_q;
  assign memWriteLeft = wrLeft_q;
  assign memLaneEnLeft = laneLeft_q;
  assign memWdataLeft = wdataLeft_q;
  assign dataOutLeft = doutLeft_q;
  assign dataOeLeft = oeLeft_q;
  always @(posedge mclk) begin
    if (srst) begin
      cntLeft_q <= `CNT_RESET;
      wrLeft_q <= 1'b0;
      rdLeft_q <= 1'b0;
      rbLeft_q <= 1'b0;
      laneLeft_q <= `LANES_NONE;
      wdataLeft_q <= {`DATA_W{1'b0}};
      doutLeft_q <= {`DATA_W{1'b0}};
      oeLeft_q <= `LANES_NONE;
    end else begin
      cntLeft_q <= cntLeft_d;
      wrLeft_q <= ~chipEnableLeftN & ~readNotWriteLeft;
      rdLeft_q <= ~chipEnableLeftN & readNotWriteLeft & ~outputEnableLeftN & (opLeft != OP_READBACK);
      rbLeft_q <= readNotWriteLeft & ~outputEnableLeftN & (opLeft == OP_READBACK);
      // byte-lane enables gate both writes and read drivers
      laneLeft_q <= ~{byteLaneEnable3N, byteLaneEnable2N, byteLaneEnable1N, byteLaneEnable0N};
      wdataLeft_q <= dataInLeft;
      if (rdLeft_q) begin
        doutLeft_q <= memRdataLeft;
        oeLeft_q <= laneLeft_q;
      end else if (rbLeft_q) begin
        doutLeft_q <= {{(`DATA_W-`ADDR_W){1'b0}}, cntLeft_q} << `RB36_LSB;
        oeLeft_q <= `LANES_LOW_HALF;
      end else begin
        oeLeft_q <= `LANES_NONE;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // right port request stage and output stage
  // ----------------------------------------------------------------------------
  assign memAddrRight = cntRight_q;
  assign memSubRight = subRight_q;
  assign memWriteRight = wrRight_q;
  assign memLaneEnRight = laneRight_q;
  assign memWdataRight = wdataRight_q;
  assign dataOutRight = doutRight_q;
  assign dataOeRight = oeRight_q;
  always @(posedge mclk) begin
    if (srst) begin
      cntRight_q <= `CNT_RESET;
      subRight_q <= `SUB_FIRST_LE;
      wrRight_q <= 1'b0;
      rdRight_q <= 1'b0;
      rbRight_q <= 1'b0;
      rbPhaseRight_q <= 1'b0;
      rbExtRight_q <= 1'b0;
      laneRight_q <= `LANES_NONE;
      wdataRight_q <= {`DATA_W{1'b0}};
      doutRight_q <= {`DATA_W{1'b0}};
      oeRight_q <= `LANES_NONE;
    end else begin
      cntRight_q <= cntRight_d;
      subRight_q <= subRight_d;
      wrRight_q <= ~chipEnableRightN & ~readNotWriteRight;
      rdRight_q <= ~chipEnableRightN & readNotWriteRight & ~outputEnableRightN & (opRight != OP_READBACK);
      rbRight_q <= readNotWriteRight & ~outputEnableRightN & (opRight == OP_READBACK);
      laneRight_q <= laneRightNext;
      // narrow pieces are copied to every lane; lane enables pick the target
      if (modeX9) begin
        wdataRight_q <= {`LANES{dataInRight[`LANE_W-1:0]}};
      end else if (modeX18) begin
        wdataRight_q <= {2{dataInRight[`HALF_W-1:0]}};
      end else begin
        wdataRight_q <= dataInRight;
      end
      // x9 read-back: first cycle high bits, later cycles the low piece
      if (rbRight_q && modeX9) begin
        rbPhaseRight_q <= 1'b1;
      end else if (!rbExtRight_q) begin
        rbPhaseRight_q <= 1'b0;
      end
      // the low piece outlives the request by one cycle in x9
      rbExtRight_q <= modeX9 & rbRight_q & rbPhaseRight_q & ~(readNotWriteRight & ~outputEnableRightN &
        (opRight == OP_READBACK));
      if (rdRight_q) begin
        if (modeX9) begin
          doutRight_q <= {{(`DATA_W-`LANE_W){1'b0}}, memRdataRight[subRight_q*`LANE_W +: `LANE_W]};
          oeRight_q <= `LANES_FIRST; // unused lanes three-stated
        end else if (modeX18) begin
          doutRight_q <= {{(`DATA_W-`HALF_W){1'b0}},
            halfWordBit ? memRdataRight[`DATA_W-1:`HALF_W] : memRdataRight[`HALF_W-1:0]};
          oeRight_q <= `LANES_LOW_HALF;
        end else begin
          doutRight_q <= memRdataRight;
          oeRight_q <= `LANES_ALL;
        end
      end else if (rbRight_q || rbExtRight_q) begin
        if (modeX9 && !rbPhaseRight_q) begin
          doutRight_q <= {{(`DATA_W-`ADDR_W+`RB9_HIGH_CNT_LSB){1'b0}},
            cntRight_q[`ADDR_W-1:`RB9_HIGH_CNT_LSB]};
          oeRight_q <= `LANES_FIRST;
        end else if (modeX9) begin
          doutRight_q <= {{(`DATA_W-`RB9_HIGH_CNT_LSB-`SUB_W){1'b0}},
            cntRight_q[`RB9_HIGH_CNT_LSB-1:0], halfWordBit, byteBit} << `RB9_BA_BIT;
          oeRight_q <= `LANES_FIRST;
        end else if (modeX18) begin
          doutRight_q <= {{(`DATA_W-`ADDR_W-1){1'b0}}, cntRight_q, halfWordBit} << `RB18_LSB;
          oeRight_q <= `LANES_LOW_HALF;
        end else begin
          doutRight_q <= {{(`DATA_W-`ADDR_W){1'b0}}, cntRight_q} << `RB36_LSB;
          oeRight_q <= `LANES_LOW_HALF;
        end
      end else begin
        oeRight_q <= `LANES_NONE;
      end
    end
  end

endmodule

// ### hw/bus_match_consts.vh
// constants for the dual-port burst counter and right-port bus-matching logic
// assumes inclusion by bare name from the design file; definitions only
`ifndef BUS_MATCH_CONSTS_VH
`define BUS_MATCH_CONSTS_VH

// ----------------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------------
`define ADDR_W 15
`define DATA_W 36
`define LANE_W 9
`define HALF_W 18
`define LANES 4
`define SUB_W 2
`define APB_AW 12
`define CFG_W 3

// ----------------------------------------------------------------------------
// counter and sub-counter values
// ----------------------------------------------------------------------------
`define CNT_RESET 15'h0000
`define CNT_ONE 15'h0001
`define SUB_FIRST_LE 2'h0
`define SUB_LAST_X9 2'h3
`define SUB_LAST_X18 2'h2
`define SUB_STEP_X9 2'h1
`define SUB_STEP_X18 2'h2

// ----------------------------------------------------------------------------
// lane groups
// ----------------------------------------------------------------------------
`define LANES_ALL 4'hf
`define LANES_LOW_HALF 4'h3
`define LANES_HIGH_HALF 4'hc
`define LANES_FIRST 4'h1
`define LANES_NONE 4'h0

// ----------------------------------------------------------------------------
// counter read-back field positions
// ----------------------------------------------------------------------------
`define RB36_LSB 3
`define RB18_LSB 2
`define RB9_BA_BIT 1
`define RB9_HIGH_CNT_LSB 6

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define OFS_CFG 12'h000
`define OFS_CNT_LEFT 12'h004
`define OFS_CNT_RIGHT 12'h008
`define CFG_BM_BIT 0
`define CFG_SIZE_BIT 1
`define CFG_BE_BIT 2
`define CFG_RESET 3'h0
`define WORD_ZERO 32'h0000_0000

`endif

// ### testbench/dual_port_bus_match_counter_asserts.sv
// concurrent checks on the burst counters and the right-port sub-counter
// assumes binding to the top module; port config is mirrored from apb writes
`timescale 1ns/1ps

module dual_port_bus_match_counter_asserts (
  input wire mclk,
  input wire srst,
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire [14:0] addrLeft,
  input wire addressStrobeLoadLeftN,
  input wire countAdvanceEnableLeftN,
  input wire counterClearLeftN,
  input wire chipEnableLeftN,
  input wire readNotWriteLeft,
  input wire outputEnableLeftN,
  input wire byteLaneEnable0N,
  input wire byteLaneEnable1N,
  input wire byteLaneEnable2N,
  input wire byteLaneEnable3N,
  input wire [35:0] dataOutLeft,
  input wire [3:0] dataOeLeft,
  input wire [14:0] memAddrLeft,
  input wire memWriteLeft,
  input wire [3:0] memLaneEnLeft,
  input wire addressStrobeLoadRightN,
  input wire countAdvanceEnableRightN,
  input wire counterClearRightN,
  input wire [14:0] memAddrRight,
  input wire [1:0] memSubRight
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // the cfg register is internal, so track what apb wrote to it
  logic [2:0] cfgQ;
  wire ldL = counterClearLeftN && !addressStrobeLoadLeftN && !countAdvanceEnableLeftN;
  wire incL = counterClearLeftN && addressStrobeLoadLeftN && !countAdvanceEnableLeftN;
  wire incR = counterClearRightN && addressStrobeLoadRightN && !countAdvanceEnableRightN;
  wire holdR = counterClearRightN && addressStrobeLoadRightN && countAdvanceEnableRightN;
  wire rbL = counterClearLeftN && !addressStrobeLoadLeftN && countAdvanceEnableLeftN && !chipEnableLeftN
    && readNotWriteLeft && !outputEnableLeftN;
  wire [3:0] lanesL = ~{byteLaneEnable3N, byteLaneEnable2N, byteLaneEnable1N, byteLaneEnable0N};

  always @(posedge mclk) begin
    if (srst) begin
      cfgQ <= 3'h0;
    end else if (psel && penable && pwrite && paddr == 12'h000 && pstrb[0]) begin
      cfgQ <= pwdata[2:0];
    end
  end

  property p_load_left;
    ldL |=> memAddrLeft == $past(addrLeft);
  endproperty
  a_load_left: assert property (p_load_left) else $error("left load missed");
  property p_incr_left;
    incL |=> memAddrLeft == $past(memAddrLeft) + 15'h0001;
  endproperty
  a_incr_left: assert property (p_incr_left) else $error("left increment wrong");
  property p_clear_right;
    !counterClearRightN |=> memAddrRight == 15'h0000 && memSubRight == ((cfgQ[0] && cfgQ[2]) ? {1'h1, cfgQ[1]} : 2'h0);
  endproperty
  a_clear_right: assert property (p_clear_right) else $error("right clear wrong");
  property p_hold_right;
    holdR |=> $stable(memAddrRight) && $stable(memSubRight);
  endproperty
  a_hold_right: assert property (p_hold_right) else $error("right hold moved");
  property p_readback_left;
    rbL |=> ##1 dataOeLeft == 4'h3 && dataOutLeft[17:3] == $past(memAddrLeft);
  endproperty
  a_readback_left: assert property (p_readback_left) else $error("left readback wrong");
  property p_lanes_left;
    !chipEnableLeftN && !readNotWriteLeft |=> memWriteLeft && memLaneEnLeft == $past(lanesL);
  endproperty
  a_lanes_left: assert property (p_lanes_left) else $error("left lanes wrong");
  property p_x9_step;
    cfgQ[1:0] == 2'h3 && incR |=> memSubRight == $past(memSubRight) + (cfgQ[2] ? 2'h3 : 2'h1)
      && memAddrRight == $past(memAddrRight) + {14'h0, $past(memSubRight) == {2{~cfgQ[2]}}};
  endproperty
  a_x9_step: assert property (p_x9_step) else $error("byte sequence wrong");
  property p_x18_step;
    cfgQ[1:0] == 2'h1 && incR |=> memSubRight == ($past(memSubRight) ^ 2'h2)
      && memAddrRight == $past(memAddrRight) + {14'h0, $past(memSubRight) == {~cfgQ[2], 1'h0}};
  endproperty
  a_x18_step: assert property (p_x18_step) else $error("half sequence wrong");
endmodule

bind dual_port_bus_match_counter dual_port_bus_match_counter_asserts chk (.*);

// ### testbench/dual_port_array_model.sv
// behavioural dual-port array behind both memory ports
// assumes per-lane writes at the edge and combinational reads
`timescale 1ns/1ps

module dual_port_array_model (
  input wire mclk,
  input wire [14:0] memAddrLeft,
  input wire memWriteLeft,
  input wire [3:0] memLaneEnLeft,
  input wire [35:0] memWdataLeft,
  output wire [35:0] memRdataLeft,
  input wire [14:0] memAddrRight,
  input wire memWriteRight,
  input wire [3:0] memLaneEnRight,
  input wire [35:0] memWdataRight,
  output wire [35:0] memRdataRight
);
  logic [35:0] cells [0:32767];

  // whole word on both sides; the right port picks its own piece
  assign memRdataLeft = cells[memAddrLeft];
  assign memRdataRight = cells[memAddrRight];

  always @(posedge mclk) begin
    for (int i = 0; i < 4; i++) begin
      if (memWriteLeft && memLaneEnLeft[i]) begin
        cells[memAddrLeft][i*9 +: 9] <= memWdataLeft[i*9 +: 9];
      end
      if (memWriteRight && memLaneEnRight[i]) begin
        cells[memAddrRight][i*9 +: 9] <= memWdataRight[i*9 +: 9];
      end
    end
  end
endmodule

// ### testbench/test_dual_port_bus_match_counter.sv
// self-checking bench: apb config, left bursts, right bus matching, read-back
// assumes the design, its header and the array model are compiled alongside
`timescale 1ns/1ps
`include "bus_match_consts.vh"

module test_dual_port_bus_match_counter;
  // controls {clearN, strobeN, countN, chipEnN, readNotWrite}
  localparam logic [4:0] LDW = 5'h10, LDR = 5'h11, INW = 5'h18, INR = 5'h19;
  localparam logic [4:0] RB = 5'h15, IDL = 5'h1e, CLR = 5'h0e, LDX = 5'h12;
  localparam logic [2:0] CFGS [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h3, 3'h7};
  logic mclk = 1'h0, srst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  logic [14:0] addrLeft = 15'h0000, addrRight = 15'h0000;
  logic addressStrobeLoadLeftN = 1'h1, countAdvanceEnableLeftN = 1'h1, counterClearLeftN = 1'h1;
  logic addressStrobeLoadRightN = 1'h1, countAdvanceEnableRightN = 1'h1, counterClearRightN = 1'h1;
  logic chipEnableLeftN = 1'h1, chipEnableRightN = 1'h1, readNotWriteLeft = 1'h1, readNotWriteRight = 1'h1;
  logic outputEnableLeftN = 1'h0, outputEnableRightN = 1'h0;
  logic byteLaneEnable0N = 1'h0, byteLaneEnable1N = 1'h0, byteLaneEnable2N = 1'h0, byteLaneEnable3N = 1'h0;
  logic [35:0] dataInLeft = 36'h0_0000_0000, dataInRight = 36'h0_0000_0000;
  wire [31:0] prdata;
  wire pready, pslverr, memWriteLeft, memWriteRight;
  wire [35:0] dataOutLeft, dataOutRight, memWdataLeft, memWdataRight, memRdataLeft, memRdataRight;
  wire [3:0] dataOeLeft, dataOeRight, memLaneEnLeft, memLaneEnRight;
  wire [14:0] memAddrLeft, memAddrRight;
  wire [1:0] memSubRight;
  logic [75:0] q [2][$];
  logic [35:0] sh [int];
  int errors = 0, n_compared = 0;

  dual_port_bus_match_counter DUT (.*);
  dual_port_array_model mem (.*);

  initial begin
    forever #2 mclk = ~mclk;
  end

  task chk(input bit ok, input string m);
    n_compared++;
    if (!ok) begin
      errors++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask

  task summarize;
    if (errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task apb(input [11:0] a, input w, input [31:0] wd, output [31:0] rd, output e);
    @(posedge mclk);
    psel <= 1'h1;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'h1;
    // any number of wait states; only the watchdog ends a hang
    do @(posedge mclk); while (pready !== 1'h1);
    rd = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task step(input bit p, input [4:0] c, input [14:0] a, input [35:0] d);
    @(posedge mclk);
    if (p) begin
      {counterClearRightN, addressStrobeLoadRightN, countAdvanceEnableRightN,
        chipEnableRightN, readNotWriteRight} <= c;
      addrRight <= a;
      dataInRight <= d;
    end else begin
      {counterClearLeftN, addressStrobeLoadLeftN, countAdvanceEnableLeftN,
        chipEnableLeftN, readNotWriteLeft} <= c;
      addrLeft <= a;
      dataInLeft <= d;
    end
  endtask

  task push(input bit p, input [3:0] o, input [35:0] m, input [35:0] v);
    q[p].push_back({o, m, v & m});
  endtask

  // ---------------------------------------------------------------------------
  // output monitor
  // ---------------------------------------------------------------------------
  task mon(input bit p, input [3:0] o, input [35:0] d);
    logic [75:0] x;
    if (o !== 4'h0) begin
      x = (q[p].size() == 0) ? 76'h0 : q[p].pop_front();
      chk(o === x[75:72] && (d & x[71:36]) === x[35:0], "read data");
    end
  endtask

  always @(negedge mclk) begin
    if (!srst) begin
      mon(0, dataOeLeft, dataOutLeft);
      mon(1, dataOeRight, dataOutRight);
    end
  end

  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    summarize;
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    logic [31:0] rd;
    logic er;
    logic [35:0] w, m;
    logic [14:0] a, b;
    logic [3:0] l;
    logic [1:0] sub;
    logic [2:0] cfg;
    int n, wid, idx;
    rd = $urandom(32'h4a30);
    repeat (20) @(posedge mclk);
    srst <= 1'h0;
    apb(`OFS_CFG, 1'h0, 32'h0000_0000, rd, er);
    chk(rd === 32'h0000_0000 && er === 1'h0, "cfg reset");
    apb(12'h0fc, 1'h0, 32'h0000_0000, rd, er);
    chk(er === 1'h1, "unmapped access");
    a = 15'($urandom);
    for (int i = 0; i < 4; i++) begin
      w = {$urandom, $urandom};
      sh[15'(a + i)] = w;
      step(0, i ? INW : LDW, a, w);
    end
    l = 4'($urandom);
    w = {$urandom, $urandom};
    for (int j = 0; j < 4; j++) m[j*9 +: 9] = {9{l[j]}};
    step(0, LDW, a + 15'h0001, w);
    {byteLaneEnable3N, byteLaneEnable2N, byteLaneEnable1N, byteLaneEnable0N} <= ~l;
    sh[15'(a + 1)] = (sh[15'(a + 1)] & ~m) | (w & m);
    step(0, IDL, a, 36'h0_0000_0000);
    {byteLaneEnable3N, byteLaneEnable2N, byteLaneEnable1N, byteLaneEnable0N} <= 4'h0;
    for (int i = 0; i < 4; i++) begin
      step(0, i ? INR : LDR, a, 36'h0_0000_0000);
      push(0, 4'hf, '1, sh[15'(a + i)]);
    end
    // chip enable high must not stop the load
    b = 15'($urandom);
    step(0, LDX, b, 36'h0_0000_0000);
    step(0, RB, a, 36'h0_0000_0000);
    push(0, 4'h3, 36'h0_0003_fff8, {18'h0, b, 3'h0});
    step(0, CLR, a, 36'h0_0000_0000);
    step(0, RB, a, 36'h0_0000_0000);
    push(0, 4'h3, 36'h0_0003_fff8, 36'h0_0000_0000);
    step(0, IDL, a, 36'h0_0000_0000);
    for (int c = 0; c < 6; c++) begin
      cfg = CFGS[c];
      b = 15'(a + 8 + c);
      apb(`OFS_CFG, 1'h1, {29'h0, cfg}, rd, er);
      apb(`OFS_CFG, 1'h0, 32'h0000_0000, rd, er);
      chk(rd === {29'h0, cfg} && er === 1'h0, "cfg readback");
      n = !cfg[0] ? 1 : cfg[1] ? 4 : 2;
      wid = 36 / n;
      m = (36'h1 << wid) - 1;
      for (int i = 0; i < 2 * n; i++) begin
        idx = (cfg[2] && n > 1) ? n - 1 - i % n : i % n;
        step(1, i ? INR : LDR, a, 36'h0_0000_0000);
        push(1, n == 4 ? 4'h1 : n == 2 ? 4'h3 : 4'hf, m, sh[15'(a + i / n)] >> (wid * idx));
      end
      w = {$urandom, $urandom};
      for (int i = 0; i < n; i++) begin
        idx = (cfg[2] && n > 1) ? n - 1 - i % n : i % n;
        step(1, i ? INW : LDW, b, ({$urandom, $urandom} & ~m) | ((w >> (wid * idx)) & m));
      end
      step(1, IDL, b, 36'h0_0000_0000);
      step(0, LDR, b, 36'h0_0000_0000);
      push(0, 4'hf, '1, w);
      step(0, IDL, b, 36'h0_0000_0000);
      apb(`OFS_CNT_RIGHT, 1'h0, 32'h0000_0000, rd, er);
      chk(rd[14:0] === b && er === 1'h0, "right counter");
      step(1, LDX, b, 36'h0_0000_0000);
      step(1, RB, b, 36'h0_0000_0000);
      if (n == 4) step(1, RB, b, 36'h0_0000_0000);
      step(1, IDL, b, 36'h0_0000_0000);
      sub = (cfg[2] && n > 1) ? {1'h1, n == 4} : 2'h0;
      if (n == 1) push(1, 4'h3, 36'h0_0003_fff8, {18'h0, b, 3'h0});
      if (n == 2) push(1, 4'h3, 36'h0_0003_fffc, {18'h0, b, sub[1], 2'h0});
      if (n == 4) begin
        push(1, 4'h1, 36'h0_0000_01ff, {27'h0, b[14:6]});
        repeat (2) push(1, 4'h1, 36'h0_0000_01fe, {27'h0, b[5:0], sub, 1'h0});
      end
    end
    step(1, CLR, a, 36'h0_0000_0000);
    step(1, IDL, a, 36'h0_0000_0000);
    repeat (6) @(posedge mclk);
    chk(q[0].size() == 0 && q[1].size() == 0, "missing output");
    summarize;
  end
endmodule
